// [rtl/csd_pkg.sv]
/*
 * Package for the chained serial converter master: register word addresses,
 * field positions, reset values and the engine state encoding.
 * Assumes a 16-bit word-addressed slow-control bus and a 100 MHz mclk.
 */
package csd_pkg;

	// ------------------------------------------------------------------
	// Register word addresses
	// ------------------------------------------------------------------
	localparam logic [15:0] ADDR_SLOT_BASE = 16'hd400; // Sixteen command slots.
	localparam logic [15:0] ADDR_MASK      = 16'hd410; // Chain select mask.
	localparam logic [15:0] ADDR_CTRL      = 16'hd411; // Transfer control.
	localparam logic [15:0] ADDR_RB        = 16'hd412; // Received word.
	localparam logic [15:0] ADDR_LOCK      = 16'hd413; // Exclusive lock.
	localparam logic [15:0] ADDR_CLR       = 16'hd414; // Clear output.
	localparam logic [15:0] ADDR_INV       = 16'hd418; // Output polarity.
	localparam logic [15:0] ADDR_WL        = 16'hd419; // Bits per word.
	localparam logic [15:0] ADDR_HALF      = 16'hd41a; // Clock half period.

	// ------------------------------------------------------------------
	// Field positions and sizes
	// ------------------------------------------------------------------
	localparam int          SLOT_COUNT  = 16;       // Number of command slots.
	localparam int          CHAINS      = 16;       // Chip select outputs.
	localparam int          SINGLE_BIT  = 7;        // Multi-write single device.
	localparam int          RBLOCK_BIT  = 16;       // Lock until read-back read.
	localparam int          SECURE_BIT  = 17;       // Secure access flag.
	localparam int          BUSY_BIT    = 31;       // Busy shown on control read.
	localparam logic [4:0]  LEN_MAX     = 5'h10;    // Longest transfer in words.
	localparam logic [5:0]  WL_MAX      = 6'h20;    // Widest serial word.

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [5:0]  WL_RESET    = 6'h20;    // 32 bits per word.
	localparam logic [7:0]  HALF_RESET  = 8'h07;    // 7 mclk per half period.

	// ------------------------------------------------------------------
	// Engine states, one-hot
	// ------------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_FETCH = 7'h02,
		ST_LOAD  = 7'h04,
		ST_LOW   = 7'h08,
		ST_HIGH  = 7'h10,
		ST_GAP   = 7'h20,
		ST_END   = 7'h40
	} csd_state_e;

endpackage

// [rtl/csd_sync.sv]
/*
 * Two flip-flop synchroniser for one level from outside the mclk domain.
 * Assumes the level is slow compared with mclk.
 */
`timescale 1ns/1ps
module csd_sync (
	// Clock and reset.
	input  wire logic mclk,
	input  wire logic rst_b,
	// Asynchronous level in, synchronised level out.
	input  wire logic din,
	output logic      dout
);

	// ------------------------------------------------------------------
	// Synchroniser chain
	// ------------------------------------------------------------------
	logic meta_q; // First stage, read only by the second stage.
	logic sync_q; // Second stage, safe to use.

	// Both stages clear on reset so the output is defined at once.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end

	assign dout = sync_q;

endmodule

// [rtl/csd_slot_mem.sv]
/*
 * Sixteen-word command slot memory with one write port and one
 * registered read port.
 * Assumes the caller arbitrates the read address between bus and engine.
 */
`timescale 1ns/1ps
module csd_slot_mem (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// Write port.
	input  wire logic        we,
	input  wire logic [3:0]  waddr,
	input  wire logic [31:0] wdata,
	// Registered read port.
	input  wire logic [3:0]  raddr,
	output logic      [31:0] rdata
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [31:0] mem_q [csd_pkg::SLOT_COUNT]; // Slot contents, no reset.
	logic [31:0] rd_q;                        // Read data register.

	// The array holds no reset so it can map onto distributed RAM.
	always_ff @(posedge mclk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	// Read data lags the address by one clock.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rd_q <= 32'h0;
		end else begin
			rd_q <= mem_q[raddr];
		end
	end

	assign rdata = rd_q;

endmodule

// [rtl/csd_spi_master.sv]
/*
 * Chained serial converter master: register file on the slow-control
 * bus, command slot memory, and a shift engine driving clock, data,
 * chain selects and a clear line, with read-back capture and locks.
 * Assumes one-cycle read and write strobes on the bus and mclk at 100 MHz.
 */
`timescale 1ns/1ps
module csd_spi_master (
	// System clock and synchronous reset.
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// Slow-control register port.
	input  wire logic [15:0] bus_addr,
	input  wire logic [31:0] bus_wdata,
	input  wire logic        bus_read,
	input  wire logic        bus_write,
	output logic      [31:0] bus_rdata,
	output logic             bus_ack,
	output logic             bus_nack,
	output logic             bus_unknown,
	// Serial chain pins.
	output logic             spi_sck,
	output logic             spi_sdo,
	output logic      [15:0] spi_cs,
	output logic             spi_clr,
	input  wire logic        spi_sdi
);

	// ------------------------------------------------------------------
	// Address decode and access qualification
	// ------------------------------------------------------------------
	logic hit_slot, hit_mask, hit_ctrl, hit_rb, hit_lock;
	logic hit_clr, hit_inv, hit_wl, hit_half, hit_any;
	logic busy;       // Engine is not idle.
	logic wr_refused; // Write answered with no-more-data.
	logic sec_drop;   // Control write silently dropped by the lock.
	logic wr_ok;      // Write that takes effect.
	logic go;         // Transfer start.
	logic [31:0] mem_rd;
	logic        sdi_s;

	assign hit_slot = bus_addr[15:4] == csd_pkg::ADDR_SLOT_BASE[15:4];
	assign hit_mask = bus_addr == csd_pkg::ADDR_MASK;
	assign hit_ctrl = bus_addr == csd_pkg::ADDR_CTRL;
	assign hit_rb   = bus_addr == csd_pkg::ADDR_RB;
	assign hit_lock = bus_addr == csd_pkg::ADDR_LOCK;
	assign hit_clr  = bus_addr == csd_pkg::ADDR_CLR;
	assign hit_inv  = bus_addr == csd_pkg::ADDR_INV;
	assign hit_wl   = bus_addr == csd_pkg::ADDR_WL;
	assign hit_half = bus_addr == csd_pkg::ADDR_HALF;
	assign hit_any  = hit_slot | hit_mask | hit_ctrl | hit_rb | hit_lock |
	                  hit_clr | hit_inv | hit_wl | hit_half;

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	logic [15:0] mask_q, mask_d;     // Chain select mask.
	logic [4:0]  len_q, len_d;       // Words in the transfer.
	logic        single_q, single_d; // Separate commands per word.
	logic        rblk_q, rblk_d;     // Read-back lock.
	logic        excl_q, excl_d;     // Exclusive lock.
	logic        clr_q, clr_d;       // Clear output level.
	logic        inv_q, inv_d;       // Output inversion.
	logic [5:0]  wl_q, wl_d;         // Bits per word.
	logic [7:0]  half_q, half_d;     // Half period in mclk.
	logic [31:0] rx_q, rx_d;         // Received serial bits.
	logic [31:0] rx_mask;            // Bits valid at this word length.

	// Busy blocks every write; a read-back lock also blocks new starts.
	assign wr_refused = bus_write & hit_any &
	                    (busy | (hit_ctrl & rblk_q));
	// Under the exclusive lock, unflagged control writes vanish.
	assign sec_drop = bus_write & hit_ctrl & ~wr_refused & excl_q &
	                  ~bus_wdata[csd_pkg::SECURE_BIT];
	assign wr_ok = bus_write & hit_any & ~wr_refused & ~sec_drop & ~hit_rb;
	// A zero length starts nothing, so busy never flickers.
	assign go = wr_ok & hit_ctrl & (bus_wdata[4:0] != 5'h00);

	// Upper bits beyond the word length are masked on read-back.
	assign rx_mask = (wl_q == csd_pkg::WL_MAX) ? 32'hffffffff :
	                 ((32'h1 << wl_q) - 32'h1);

	// Register writes and the read-back lock.
	always_comb begin
		mask_d   = mask_q;
		len_d    = len_q;
		single_d = single_q;
		rblk_d   = rblk_q;
		excl_d   = excl_q;
		clr_d    = clr_q;
		inv_d    = inv_q;
		wl_d     = wl_q;
		half_d   = half_q;
		if (bus_read && hit_rb) begin
			rblk_d = 1'b0; // Reading the result releases the lock.
		end
		if (wr_ok) begin
			if (hit_mask) begin
				mask_d = bus_wdata[15:0];
			end
			if (hit_ctrl) begin
				// Lengths above sixteen are clamped to the slot count.
				len_d    = (bus_wdata[4:0] > csd_pkg::LEN_MAX) ?
				           csd_pkg::LEN_MAX : bus_wdata[4:0];
				single_d = bus_wdata[csd_pkg::SINGLE_BIT];
				if (bus_wdata[csd_pkg::RBLOCK_BIT]) begin
					rblk_d = 1'b1; // Set wins over a same-cycle read.
				end
			end
			if (hit_lock) begin
				excl_d = bus_wdata[csd_pkg::SECURE_BIT];
			end
			if (hit_clr) begin
				clr_d = bus_wdata[0];
			end
			if (hit_inv) begin
				inv_d = bus_wdata[0];
			end
			// Out-of-range word lengths are ignored.
			if (hit_wl && bus_wdata[5:0] != 6'h00 &&
			    bus_wdata[5:0] <= csd_pkg::WL_MAX) begin
				wl_d = bus_wdata[5:0];
			end
			if (hit_half) begin
				half_d = bus_wdata[7:0];
			end
		end
	end

	// Configuration flip-flops.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			mask_q   <= 16'h0000;
			len_q    <= 5'h00;
			single_q <= 1'b0;
			rblk_q   <= 1'b0;
			excl_q   <= 1'b0;
			clr_q    <= 1'b0;
			inv_q    <= 1'b0;
			wl_q     <= csd_pkg::WL_RESET;
			half_q   <= csd_pkg::HALF_RESET;
		end else begin
			mask_q   <= mask_d;
			len_q    <= len_d;
			single_q <= single_d;
			rblk_q   <= rblk_d;
			excl_q   <= excl_d;
			clr_q    <= clr_d;
			inv_q    <= inv_d;
			wl_q     <= wl_d;
			half_q   <= half_d;
		end
	end

	// ------------------------------------------------------------------
	// Slot memory and input synchroniser
	// ------------------------------------------------------------------
	logic [3:0] idx_q, idx_d; // Slot being sent.

	// The engine owns the read port while busy; bus slot reads are refused.
	csd_slot_mem u_mem (
		.mclk  (mclk),
		.rst_b (rst_b),
		.we    (wr_ok & hit_slot),
		.waddr (bus_addr[3:0]),
		.wdata (bus_wdata),
		.raddr (busy ? idx_q : bus_addr[3:0]),
		.rdata (mem_rd)
	);

	csd_sync u_sdi_sync (
		.mclk  (mclk),
		.rst_b (rst_b),
		.din   (spi_sdi),
		.dout  (sdi_s)
	);

	// ------------------------------------------------------------------
	// Shift engine
	// ------------------------------------------------------------------
	csd_pkg::csd_state_e st_q, st_d;
	logic [7:0]  cnt_q, cnt_d;     // Half period countdown.
	logic [5:0]  bit_q, bit_d;     // Bits left in this word.
	logic [31:0] sh_q, sh_d;       // Outgoing word, MSB at bit 31.
	logic        sck_q, sck_d;     // Serial clock level.
	logic        cs_on_q, cs_on_d; // Chain selects asserted.

	assign busy = st_q != csd_pkg::ST_IDLE;

	// Next state of the engine.
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		bit_d   = bit_q;
		idx_d   = idx_q;
		sh_d    = sh_q;
		sck_d   = sck_q;
		cs_on_d = cs_on_q;
		rx_d    = rx_q;
		case (st_q)
			csd_pkg::ST_IDLE: begin
				if (go) begin
					idx_d = 4'h0;
					st_d  = csd_pkg::ST_FETCH;
				end
			end
			csd_pkg::ST_FETCH: begin
				st_d = csd_pkg::ST_LOAD; // Memory read latency.
			end
			csd_pkg::ST_LOAD: begin
				// Left-justify so the first bit sent is bit wl-1.
				sh_d    = mem_rd << (csd_pkg::WL_MAX - wl_q);
				bit_d   = wl_q;
				cnt_d   = half_q;
				cs_on_d = 1'b1;
				st_d    = csd_pkg::ST_LOW;
			end
			csd_pkg::ST_LOW: begin
				if (cnt_q > 8'h01) begin
					cnt_d = cnt_q - 8'h01;
				end else begin
					sck_d = 1'b1;
					cnt_d = half_q;
					rx_d  = {rx_q[30:0], sdi_s};
					st_d  = csd_pkg::ST_HIGH;
				end
			end
			csd_pkg::ST_HIGH: begin
				if (cnt_q > 8'h01) begin
					cnt_d = cnt_q - 8'h01;
				end else begin
					sck_d = 1'b0;
					cnt_d = half_q;
					sh_d  = {sh_q[30:0], 1'b0};
					if (bit_q > 6'h01) begin
						bit_d = bit_q - 6'h01;
						st_d  = csd_pkg::ST_LOW;
					end else if ({1'b0, idx_q} == len_q - 5'h01) begin
						cs_on_d = 1'b0; // Released only after last bit.
						st_d    = csd_pkg::ST_END;
					end else begin
						idx_d = idx_q + 4'h1;
						if (single_q) begin
							cs_on_d = 1'b0; // Each command latches alone.
							st_d    = csd_pkg::ST_GAP;
						end else begin
							st_d = csd_pkg::ST_FETCH; // Selects stay on.
						end
					end
				end
			end
			csd_pkg::ST_GAP, csd_pkg::ST_END: begin
				// Selects stay idle a half period before the next step.
				if (cnt_q > 8'h01) begin
					cnt_d = cnt_q - 8'h01;
				end else if (st_q == csd_pkg::ST_GAP) begin
					st_d = csd_pkg::ST_FETCH;
				end else begin
					st_d = csd_pkg::ST_IDLE;
				end
			end
			default: begin
				st_d    = csd_pkg::ST_IDLE;
				sck_d   = 1'b0;
				cs_on_d = 1'b0;
			end
		endcase
	end

	// Engine flip-flops.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_q    <= csd_pkg::ST_IDLE;
			cnt_q   <= 8'h00;
			bit_q   <= 6'h00;
			idx_q   <= 4'h0;
			sh_q    <= 32'h0;
			sck_q   <= 1'b0;
			cs_on_q <= 1'b0;
			rx_q    <= 32'h0;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			bit_q   <= bit_d;
			idx_q   <= idx_d;
			sh_q    <= sh_d;
			sck_q   <= sck_d;
			cs_on_q <= cs_on_d;
			rx_q    <= rx_d;
		end
	end

	// ------------------------------------------------------------------
	// Bus answer and pin outputs
	// ------------------------------------------------------------------
	logic        ack_d, nack_d, unk_d, msel_d, msel_q;
	logic [31:0] rv_d, rv_q;
	logic        o_sck_d, o_sdo_d, o_clr_d;
	logic [15:0] o_cs_d;

	// Answers one cycle after the strobe; slot reads come from the memory.
	always_comb begin
		unk_d  = (bus_read | bus_write) & ~hit_any;
		nack_d = wr_refused | (bus_read & hit_slot & busy);
		ack_d  = (bus_read | bus_write) & hit_any & ~nack_d;
		msel_d = bus_read & hit_slot & ~busy;
		rv_d   = 32'h0;
		if (bus_read) begin
			if (hit_mask) begin
				rv_d = {16'h0, mask_q};
			end else if (hit_ctrl) begin
				rv_d = {busy, 14'h0, rblk_q, 8'h0, single_q, 2'h0, len_q};
			end else if (hit_rb) begin
				rv_d = rx_q & rx_mask;
			end else if (hit_lock) begin
				rv_d = {14'h0, excl_q, 17'h0};
			end else if (hit_clr) begin
				rv_d = {31'h0, clr_q};
			end else if (hit_inv) begin
				rv_d = {31'h0, inv_q};
			end else if (hit_wl) begin
				rv_d = {26'h0, wl_q};
			end else if (hit_half) begin
				rv_d = {24'h0, half_q};
			end
		end
		// Every output pin passes through the polarity bit.
		o_sck_d = sck_q ^ inv_q;
		o_sdo_d = sh_q[31] ^ inv_q;
		o_cs_d  = (cs_on_q ? mask_q : 16'h0000) ^ {16{inv_q}};
		o_clr_d = clr_q ^ inv_q;
	end

	// Answer and pin flip-flops.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			bus_ack     <= 1'b0;
			bus_nack    <= 1'b0;
			bus_unknown <= 1'b0;
			msel_q      <= 1'b0;
			rv_q        <= 32'h0;
			spi_sck     <= 1'b0;
			spi_sdo     <= 1'b0;
			spi_cs      <= 16'h0000;
			spi_clr     <= 1'b0;
		end else begin
			bus_ack     <= ack_d;
			bus_nack    <= nack_d;
			bus_unknown <= unk_d;
			msel_q      <= msel_d;
			rv_q        <= rv_d;
			spi_sck     <= o_sck_d;
			spi_sdo     <= o_sdo_d;
			spi_cs      <= o_cs_d;
			spi_clr     <= o_clr_d;
		end
	end

	assign bus_rdata = msel_q ? mem_rd : rv_q;

	// ------------------------------------------------------------------
	// Assertions and covers
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_start_ctrl_write: assert property (go |=> st_q == csd_pkg::ST_FETCH ##2
		st_q == csd_pkg::ST_LOW) else $error("transfer did not start");
	a_len_busy_ignored: assert property (busy && bus_write && hit_ctrl |=>
		bus_nack && !bus_ack && $stable(len_q)) else $error("length taken");
	a_msb_first_out: assert property (st_q == csd_pkg::ST_LOAD &&
		wl_q == csd_pkg::WL_MAX |=> sh_q[31] == $past(mem_rd[31]))
		else $error("first bit not bit 31");
	a_slot_order: assert property (st_q == csd_pkg::ST_HIGH && st_d ==
		csd_pkg::ST_FETCH |=> idx_q == $past(idx_q) + 4'h1)
		else $error("slot skipped");
	a_cs_chain_held: assert property (st_q == csd_pkg::ST_FETCH && idx_q != 4'h0 &&
		!single_q |-> cs_on_q) else $error("select dropped mid chain");
	a_single_gap: assert property (st_q == csd_pkg::ST_GAP |-> !cs_on_q && single_q)
		else $error("gap without release");
	a_half_period: assert property (st_q == csd_pkg::ST_LOAD && half_q == 8'h07 |=>
		(st_q == csd_pkg::ST_LOW)[*7] ##1 st_q == csd_pkg::ST_HIGH)
		else $error("half period wrong");
	a_write_blocked: assert property (busy && bus_write && hit_any |=>
		$stable(mask_q) && $stable(wl_q) && bus_nack) else $error("write taken");
	a_rb_lock: assert property (rblk_q && !busy && bus_write && hit_ctrl |=>
		bus_nack && st_q == csd_pkg::ST_IDLE) else $error("lock ignored");
	a_secure_drop: assert property (sec_drop |=> bus_ack &&
		st_q == csd_pkg::ST_IDLE) else $error("insecure access ran");
	a_pin_polarity: assert property (##1 spi_clr == $past(clr_q ^ inv_q) &&
		spi_sck == $past(sck_q ^ inv_q)) else $error("pin polarity wrong");
	a_end_release: assert property (st_q == csd_pkg::ST_END |-> !cs_on_q &&
		busy) else $error("busy or select wrong at end");

	c_chain_transfer: cover property (st_q == csd_pkg::ST_HIGH && st_d == csd_pkg::ST_FETCH);
	c_single_mode: cover property (st_q == csd_pkg::ST_GAP);
	c_secure_drop: cover property (sec_drop);
	c_rb_unlock: cover property (rblk_q && bus_read && hit_rb);

endmodule

// [tb/csd_dac_model.sv]
/*
 * Behavioural model of a daisy chain of two 32-bit serial converters.
 * Assumes serial clock idle low, data taken on its rise, answered on its fall.
 */
`timescale 1ns/1ps
module csd_dac_model (
	// Serial pins seen from the converter side.
	input  wire logic        sck,
	input  wire logic        sdo,
	input  wire logic        cs,
	output logic             sdi,
	// Chain content, shown so the bench can judge what arrived.
	output logic      [63:0] sr
);
	logic dout_q; // Bit now presented on the return line.

	// ----------------------------------------------------------------
	// Chain shift
	// ----------------------------------------------------------------
	// Known preload so that read-back is predictable.
	initial begin
		sr = 64'h0f1e2d3c4b5a6978;
		dout_q = 1'b0;
	end
	// The first bit must be ready before the first rise.
	always @(posedge cs) begin
		dout_q = sr[63];
	end
	// Bits enter on the rise, two chips behave as one long register.
	always @(posedge sck) begin
		if (cs) begin
			sr <= {sr[62:0], sdo};
		end
	end
	// The next bit appears on the fall.
	always @(negedge sck) begin
		if (cs) begin
			dout_q <= sr[63];
		end
	end
	// A deselected chip releases the line; show a changed level so stale data is not read.
	assign sdi = cs ? dout_q : ~dout_q;
endmodule

// [tb/tb_top.sv]
/*
 * Self-checking bench for the chained serial converter master.
 * Assumes the register bus answers one cycle after each strobe.
 */
`timescale 1ns/1ps
module tb_top;
	logic        mclk = 1'b0;   // System clock, 100 MHz.
	logic        rst_b;         // Synchronous reset, active low.
	logic [15:0] bus_addr;      // Register word address.
	logic [31:0] bus_wdata;     // Write data.
	logic        bus_read;      // Read strobe.
	logic        bus_write;     // Write strobe.
	logic [31:0] bus_rdata;     // Read data.
	logic        bus_ack;       // Access done.
	logic        bus_nack;      // Access refused.
	logic        bus_unknown;   // Unmapped address.
	logic        spi_sck;       // Serial clock pin.
	logic        spi_sdo;       // Serial data out pin.
	logic [15:0] spi_cs;        // Chain select pins.
	logic        spi_clr;       // Clear pin.
	logic        spi_sdi;       // Serial data in pin.
	logic [63:0] chain;         // Model chain content.
	logic        sck_prev;      // Serial clock one cycle ago.
	logic        cs_prev;       // First select one cycle ago.
	logic [15:0] cs_seen;       // Last non-idle select pattern.
	int          sck_rises;     // Serial clock rises counted.
	int          cs_rises;      // First-select assertions counted.
	int          hi_cnt;        // Running high time of the clock.
	int          hi_w;          // Last complete high time.
	int          cyc;           // Cycles since start.
	int          error_cnt = 0; // Mismatches.
	int          tests_run = 0; // Comparisons.
	localparam logic [2:0] ACK = 3'h1;
	localparam logic [2:0] UNK = 3'h2;
	localparam logic [2:0] NAK = 3'h4;

	always #5 mclk = ~mclk;

	csd_spi_master u_csd_spi_master (.mclk(mclk), .rst_b(rst_b), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_read(bus_read), .bus_write(bus_write),
		.bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_nack(bus_nack),
		.bus_unknown(bus_unknown), .spi_sck(spi_sck), .spi_sdo(spi_sdo),
		.spi_cs(spi_cs), .spi_clr(spi_clr), .spi_sdi(spi_sdi));
	csd_dac_model u_csd_dac_model (.sck(spi_sck), .sdo(spi_sdo), .cs(spi_cs[0]),
		.sdi(spi_sdi), .sr(chain));

	// ----------------------------------------------------------------
	// Pin monitor and watchdog
	// ----------------------------------------------------------------
	// Counts edges on the pins; the ceiling cuts a hung run short.
	always @(posedge mclk) begin
		sck_prev <= spi_sck;
		cs_prev <= spi_cs[0];
		if (spi_sck === 1'b1 && sck_prev === 1'b0) sck_rises++;
		if (spi_cs[0] === 1'b1 && cs_prev === 1'b0) cs_rises++;
		if (spi_sck === 1'b1) hi_cnt++;
		else if (sck_prev === 1'b1) begin
			hi_w = hi_cnt;
			hi_cnt = 0;
		end
		if (spi_cs !== 16'h0) cs_seen = spi_cs;
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("errors %0d comparisons %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// One strobe; the answer stands for one cycle and is taken at the next fall.
	task automatic bus(input logic [15:0] a, input logic [31:0] d, input logic w,
		output logic [31:0] q, output logic [2:0] r);
		@(negedge mclk);
		bus_addr = a;
		bus_wdata = d;
		bus_write = w;
		bus_read = ~w;
		@(negedge mclk);
		q = bus_rdata;
		r = {bus_nack, bus_unknown, bus_ack};
		bus_write = 1'b0;
		bus_read = 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [2:0] e);
		logic [31:0] q;
		logic [2:0]  r;
		bus(a, d, 1'b1, q, r);
		chk($sformatf("write answer %h", a), {61'h0, e}, {61'h0, r});
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic [2:0]  r;
		bus(a, 32'h0, 1'b0, q, r);
		chk($sformatf("read %h", a), {29'h0, ACK, e}, {29'h0, r, q});
	endtask
	// Polls the busy flag under a bounded count, then judges the pin counters.
	task automatic idle(input int n_sck, input int n_cs);
		logic [31:0] q;
		logic [2:0]  r;
		for (int i = 0; i < 3000; i++) begin
			bus(csd_pkg::ADDR_CTRL, 32'h0, 1'b0, q, r);
			if (q[31] === 1'b0) break;
		end
		chk("idle", 64'h0, {63'h0, q[31]});
		chk("sck rises", n_sck, sck_rises);
		chk("select rises", n_cs, cs_rises);
	endtask
	// Clears the pin counters, starts a transfer and waits for its end.
	task automatic run(input logic [31:0] ctrl, input int n_sck, input int n_cs);
		sck_rises = 0;
		cs_rises = 0;
		wr(csd_pkg::ADDR_CTRL, ctrl, ACK);
		idle(n_sck, n_cs);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd(csd_pkg::ADDR_WL, 32'h20);
		rd(csd_pkg::ADDR_HALF, 32'h7);
		rd(csd_pkg::ADDR_CTRL, 32'h0);
		rd(csd_pkg::ADDR_MASK, 32'h0);
		wr(16'hd415, 32'h0, UNK);
	endtask
	task automatic t_single_word();
		wr(csd_pkg::ADDR_SLOT_BASE, 32'ha5c30f96, ACK);
		wr(csd_pkg::ADDR_MASK, 32'h1, ACK);
		sck_rises = 0;
		cs_rises = 0;
		wr(csd_pkg::ADDR_CTRL, 32'h00010001, ACK);
		wr(csd_pkg::ADDR_CTRL, 32'h1, NAK);
		wr(csd_pkg::ADDR_MASK, 32'h2, NAK);
		idle(32, 1);
		chk("sent word", 64'ha5c30f96, {32'h0, chain[31:0]});
		chk("select pattern", 64'h1, {48'h0, cs_seen});
		chk("half period", 64'h7, hi_w);
		wr(csd_pkg::ADDR_CTRL, 32'h1, NAK);
		rd(csd_pkg::ADDR_RB, 32'h0f1e2d3c);
	endtask
	task automatic t_chain();
		wr(csd_pkg::ADDR_SLOT_BASE, 32'h11223344, ACK);
		wr(csd_pkg::ADDR_SLOT_BASE + 16'h1, 32'h8899aabb, ACK);
		wr(csd_pkg::ADDR_MASK, 32'h5, ACK);
		wr(csd_pkg::ADDR_HALF, 32'h3, ACK);
		run(32'h2, 64, 1);
		chk("chain", 64'h112233448899aabb, chain);
		chk("select pattern", 64'h5, {48'h0, cs_seen});
		chk("half period", 64'h3, hi_w);
		run(32'h82, 64, 2);
		chk("chain single", 64'h112233448899aabb, chain);
	endtask
	task automatic t_wordlen();
		wr(csd_pkg::ADDR_WL, 32'h10, ACK);
		wr(csd_pkg::ADDR_SLOT_BASE, 32'h1234abcd, ACK);
		run(32'h1, 16, 1);
		chk("short word", 64'habcd, {48'h0, chain[15:0]});
		wr(csd_pkg::ADDR_WL, 32'h20, ACK);
	endtask
	task automatic t_lock();
		wr(csd_pkg::ADDR_LOCK, 32'h20000, ACK);
		run(32'h1, 0, 0);
		run(32'h20001, 32, 1);
		wr(csd_pkg::ADDR_LOCK, 32'h0, ACK);
	endtask
	task automatic t_pins();
		wr(csd_pkg::ADDR_CLR, 32'h1, ACK);
		repeat (2) @(negedge mclk);
		chk("clear pin", 64'h1, {63'h0, spi_clr});
		wr(csd_pkg::ADDR_INV, 32'h1, ACK);
		repeat (2) @(negedge mclk);
		chk("inverted pins", 64'h7fffe, {45'h0, spi_sck, spi_sdo, spi_cs, spi_clr});
	endtask

	initial begin
		rst_b = 1'b0;
		bus_addr = 16'h0;
		bus_wdata = 32'h0;
		bus_read = 1'b0;
		bus_write = 1'b0;
		cyc = 0;
		hi_cnt = 0;
		hi_w = 0;
		repeat (12) @(negedge mclk);
		rst_b = 1'b1;
		t_reset();
		t_single_word();
		t_chain();
		t_wordlen();
		t_lock();
		t_pins();
		finish_test();
	end
endmodule
